// ### hdl/dap_io_port.v
/*
  two 8-bit ports a and b with mode dependent address, io and pull-up functions,
  reached over apb.
  assumes mode, hardware standby and manual reset come from pins (synchronised here),
  software standby and the address bits come from logic on pclk.
*/
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "dap_regs.vh"

// Behaviour
// - open-drain bit set: drive only low, release high; clear: full drive
// - open-drain bits act only in modes 1 to 3 and 7
// - open-drain select clears on power-on and hardware standby only
// - modes 1-3,7: port a pins are io, direction bit 1 means output
// - modes 4,5: low five a pins address; upper three address when direction 1
// - mode 6: port a pin drives address when direction 1, else input
// - port a pull-ups all pins except modes 4,5 where upper three only
// - port a pull-up on only with direction 0 and pull-up bit 1
// - port a pull-up state clears on power-on and hardware standby only
// - modes 1,4,5: every port b pin drives address
// - modes 2,6: port b pin address when direction 1, else input
// - modes 3,7: port b pin general output when direction 1, else input
// - port b direction is write-only; reads give a fixed undefined value
// - port b direction clears on power-on and hardware standby only
// - port b output data read-write, clears on power-on and hardware standby
// - port b pin read: latch where direction 1, pin level where 0
// - port b pin-state register ignores writes
// - software standby: address pins hold level or release per hold bit
// - port b pin state frozen during manual reset and software standby, except while hardware standby is active
// - port a pin read: latch where direction 1, pin level where 0
// - port b pull-ups only in modes 2,3,6,7, direction 0 and bit 1
module dap_io_port
(
  input wire pclk, // system clock
  input wire presetn, // power-on reset, low active
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [17:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  input wire [3:0] pstrb, // apb byte strobes
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error on unmapped address
  input wire [2:0] mode_pin, // operating mode pins
  input wire hw_standby_n, // hardware standby pin, low active
  input wire manual_reset_n, // manual reset pin, low active
  input wire sw_standby, // software standby from system control
  input wire [7:0] addr_a, // address bits for port a pins
  input wire [7:0] addr_b, // address bits for port b pins
  input wire [7:0] pa_in, // port a pin levels
  output reg [7:0] pa_out, // port a pin drive level
  output reg [7:0] pa_oe_n, // port a enable, low drives
  output reg [7:0] pa_pullup, // port a pull-up enable
  input wire [7:0] pb_in, // port b pin levels
  output reg [7:0] pb_out, // port b pin drive level
  output reg [7:0] pb_oe_n, // port b enable, low drives
  output reg [7:0] pb_pullup // port b pull-up enable
);

  // ==========================================================
  // pin synchronisers
  reg [2:0] mode_s1, mode;
  reg hws_s1, hws_n, mrs_s1, mrs_n;
  reg [7:0] pa_s1, pa_s2, pb_s1, pb_s2;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_s1 <= 3'h0;
      mode <= 3'h0;
      hws_s1 <= 1'b1;
      hws_n <= 1'b1;
      mrs_s1 <= 1'b1;
      mrs_n <= 1'b1;
      pa_s1 <= 8'h00;
      pa_s2 <= 8'h00;
      pb_s1 <= 8'h00;
      pb_s2 <= 8'h00;
    end
    else
    begin
      mode_s1 <= mode_pin;
      mode <= mode_s1;
      hws_s1 <= hw_standby_n;
      hws_n <= hws_s1;
      mrs_s1 <= manual_reset_n;
      mrs_n <= mrs_s1;
      pa_s1 <= pa_in;
      pa_s2 <= pa_s1;
      pb_s1 <= pb_in;
      pb_s2 <= pb_s1;
    end
  end

  wire hw_stby = ~hws_n;
  wire man_rst = ~mrs_n;

  // ==========================================================
  // apb decode
  wire [15:0] idx = paddr[17:2];
  wire setup = psel & ~penable;
  wire done = psel & penable & pready;
  wire wr_ok = done & pwrite & pstrb[0] & ~man_rst;
  reg hit;

  always @*
  begin
    case (idx)
      `DAP_IDX_PA_DIR,
      `DAP_IDX_PA_DATA,
      `DAP_IDX_PA_PIN,
      `DAP_IDX_PA_PULL,
      `DAP_IDX_PA_ODS,
      `DAP_IDX_PB_DIR,
      `DAP_IDX_PB_DATA,
      `DAP_IDX_PB_PIN,
      `DAP_IDX_PB_PULL,
      `DAP_IDX_STBY:
        hit = (paddr[1:0] == 2'b00);
      default: hit = 1'b0;
    endcase
  end

  // ==========================================================
  // registers
  reg [7:0] pa_dir, pa_data, pa_pull, pa_ods;
  reg [7:0] pb_dir, pb_data, pb_pull;
  reg hold;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pa_dir <= `DAP_RST_BYTE;
      pa_data <= `DAP_RST_BYTE;
      pa_pull <= `DAP_RST_BYTE;
      pa_ods <= `DAP_RST_BYTE;
      pb_dir <= `DAP_RST_BYTE;
      pb_data <= `DAP_RST_BYTE;
      pb_pull <= `DAP_RST_BYTE;
      hold <= 1'b0;
    end
    else if (hw_stby)
    begin
      pa_dir <= `DAP_RST_BYTE;
      pa_data <= `DAP_RST_BYTE;
      pa_pull <= `DAP_RST_BYTE;
      pa_ods <= `DAP_RST_BYTE;
      pb_dir <= `DAP_RST_BYTE;
      pb_data <= `DAP_RST_BYTE;
      pb_pull <= `DAP_RST_BYTE;
      hold <= 1'b0;
    end
    else if (wr_ok && hit)
    begin
      // manual reset blocks writes but clears nothing
      case (idx)
        `DAP_IDX_PA_DIR: pa_dir <= pwdata[7:0];
        `DAP_IDX_PA_DATA: pa_data <= pwdata[7:0];
        `DAP_IDX_PA_PULL: pa_pull <= pwdata[7:0];
        `DAP_IDX_PA_ODS: pa_ods <= pwdata[7:0];
        `DAP_IDX_PB_DIR: pb_dir <= pwdata[7:0];
        `DAP_IDX_PB_DATA: pb_data <= pwdata[7:0];
        `DAP_IDX_PB_PULL: pb_pull <= pwdata[7:0];
        `DAP_IDX_STBY: hold <= pwdata[`DAP_HOLD_BIT];
        default: hold <= hold;
      endcase
    end
  end

  // ==========================================================
  // pin state capture, frozen in manual reset and software standby unless hardware standby is active
  reg [7:0] pa_state, pb_state;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pa_state <= 8'h00;
      pb_state <= 8'h00;
    end
    else if (!(man_rst || sw_standby) || hw_stby)
    begin
      pa_state <= pa_s2;
      pb_state <= pb_s2;
    end
  end

  // ==========================================================
  // mode decode
  reg [7:0] pa_addr_m, pa_gpio_m, pa_pu_allow;
  reg pa_od_on;
  reg [7:0] pb_addr_m, pb_gpio_m, pb_pu_allow;

  always @*
  begin
    pa_addr_m = `DAP_NO_PINS;
    pa_gpio_m = pa_dir;
    pa_pu_allow = `DAP_ALL_PINS;
    pa_od_on = 1'b1;
    case (mode)
      `DAP_MODE4,
      `DAP_MODE5:
      begin
        pa_addr_m = `DAP_PA_LOW_ADDR | (pa_dir & `DAP_PA_HIGH_PINS);
        pa_gpio_m = `DAP_NO_PINS;
        pa_pu_allow = `DAP_PA_HIGH_PINS;
        pa_od_on = 1'b0;
      end
      `DAP_MODE6:
      begin
        pa_addr_m = pa_dir;
        pa_gpio_m = `DAP_NO_PINS;
        pa_od_on = 1'b0;
      end
      default: pa_od_on = 1'b1;
    endcase
  end

  always @*
  begin
    pb_addr_m = `DAP_NO_PINS;
    pb_gpio_m = pb_dir;
    pb_pu_allow = `DAP_ALL_PINS;
    case (mode)
      `DAP_MODE1,
      `DAP_MODE4,
      `DAP_MODE5:
      begin
        pb_addr_m = `DAP_ALL_PINS;
        pb_gpio_m = `DAP_NO_PINS;
        pb_pu_allow = `DAP_NO_PINS;
      end
      `DAP_MODE2,
      `DAP_MODE6:
      begin
        pb_addr_m = pb_dir;
        pb_gpio_m = `DAP_NO_PINS;
      end
      default: pb_gpio_m = pb_dir;
    endcase
  end

  wire [7:0] pa_od_m = pa_od_on ? pa_ods : `DAP_NO_PINS;
  wire [7:0] pa_pu_req = pa_pu_allow & ~pa_dir & pa_pull;
  wire [7:0] pb_pu_req = pb_pu_allow & ~pb_dir & pb_pull;

  // ==========================================================
  // output stages
  wire [7:0] next_pa_out, next_pa_oe_n, next_pa_pu;
  wire [7:0] next_pb_out, next_pb_oe_n, next_pb_pu;

  dap_pin_cell u_cell_a
  (
    .addr_mask(pa_addr_m),
    .gpio_mask(pa_gpio_m),
    .od_mask(pa_od_m),
    .pull_mask(pa_pu_req),
    .data(pa_data),
    .addr(addr_a),
    .hw_stby(hw_stby),
    .sw_stby(sw_standby),
    .hold(hold),
    .cur_out(pa_out),
    .cur_oe_n(pa_oe_n),
    .next_out(next_pa_out),
    .next_oe_n(next_pa_oe_n),
    .next_pu(next_pa_pu)
  );

  dap_pin_cell u_cell_b
  (
    .addr_mask(pb_addr_m),
    .gpio_mask(pb_gpio_m),
    .od_mask(`DAP_NO_PINS),
    .pull_mask(pb_pu_req),
    .data(pb_data),
    .addr(addr_b),
    .hw_stby(hw_stby),
    .sw_stby(sw_standby),
    .hold(hold),
    .cur_out(pb_out),
    .cur_oe_n(pb_oe_n),
    .next_out(next_pb_out),
    .next_oe_n(next_pb_oe_n),
    .next_pu(next_pb_pu)
  );

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pa_out <= 8'h00;
      pa_oe_n <= `DAP_OE_OFF;
      pa_pullup <= 8'h00;
      pb_out <= 8'h00;
      pb_oe_n <= `DAP_OE_OFF;
      pb_pullup <= 8'h00;
    end
    else
    begin
      pa_out <= next_pa_out;
      pa_oe_n <= next_pa_oe_n;
      pa_pullup <= next_pa_pu;
      pb_out <= next_pb_out;
      pb_oe_n <= next_pb_oe_n;
      pb_pullup <= next_pb_pu;
    end
  end

  // ==========================================================
  // read mux
  reg [7:0] next_rbyte;

  always @*
  begin
    next_rbyte = 8'h00;
    case (idx)
      `DAP_IDX_PA_DIR: next_rbyte = `DAP_UNDEF_READ;
      `DAP_IDX_PA_DATA: next_rbyte = pa_data;
      `DAP_IDX_PA_PIN: next_rbyte = (pa_dir & pa_data) | (~pa_dir & pa_state);
      `DAP_IDX_PA_PULL: next_rbyte = pa_pull;
      `DAP_IDX_PA_ODS: next_rbyte = pa_ods;
      `DAP_IDX_PB_DIR: next_rbyte = `DAP_UNDEF_READ;
      `DAP_IDX_PB_DATA: next_rbyte = pb_data;
      `DAP_IDX_PB_PIN: next_rbyte = (pb_dir & pb_data) | (~pb_dir & pb_state);
      `DAP_IDX_PB_PULL: next_rbyte = pb_pull;
      `DAP_IDX_STBY:
      begin
        next_rbyte[`DAP_HOLD_BIT] = hold;
        next_rbyte[`DAP_MODE_MSB:`DAP_MODE_LSB] = mode;
      end
      default: next_rbyte = 8'h00;
    endcase
  end

  // ==========================================================
  // apb answer: ready one cycle after setup
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata <= (!pwrite && hit) ? {24'h000000, next_rbyte} : 32'h00000000;
      pready <= 1'b1;
      pslverr <= ~hit;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

// ### hdl/dap_regs.vh
/*
  register indices, field positions and reset values of the dual address io port.
  assumes the includer adds two zero bits below an index to form the apb byte address.
*/
`ifndef DAP_REGS_VH
`define DAP_REGS_VH

// ==========================================================
// register indices (byte address is four times the index)
`define DAP_IDX_PA_DIR 16'hFEB9
`define DAP_IDX_PA_DATA 16'hFF69
`define DAP_IDX_PA_PIN 16'hFF59
`define DAP_IDX_PA_PULL 16'hFF70
`define DAP_IDX_PA_ODS 16'hFF77
`define DAP_IDX_PB_DIR 16'hFEBA
`define DAP_IDX_PB_DATA 16'hFF6A
`define DAP_IDX_PB_PIN 16'hFF5A
`define DAP_IDX_PB_PULL 16'hFF71
`define DAP_IDX_STBY 16'hFF7D

// ==========================================================
// reset values and fixed read answers
`define DAP_RST_BYTE 8'h00
`define DAP_UNDEF_READ 8'hFF
`define DAP_OE_OFF 8'hFF

// ==========================================================
// standby control fields
`define DAP_HOLD_BIT 3
`define DAP_MODE_LSB 0
`define DAP_MODE_MSB 2

// ==========================================================
// operating modes
`define DAP_MODE1 3'h1
`define DAP_MODE2 3'h2
`define DAP_MODE3 3'h3
`define DAP_MODE4 3'h4
`define DAP_MODE5 3'h5
`define DAP_MODE6 3'h6
`define DAP_MODE7 3'h7

// ==========================================================
// pin masks per mode
`define DAP_ALL_PINS 8'hFF
`define DAP_NO_PINS 8'h00
`define DAP_PA_LOW_ADDR 8'h1F
`define DAP_PA_HIGH_PINS 8'hE0

`endif

// ### hdl/dap_pin_cell.v
/*
  next state of the output stage of one 8-bit port: level, enable and pull-up.
  assumes the caller registers the results and feeds the current stage back.
*/
`timescale 1ns/1ps

module dap_pin_cell
(
  input wire [7:0] addr_mask, // pins that carry address
  input wire [7:0] gpio_mask, // pins that drive port data
  input wire [7:0] od_mask, // pins in open-drain form
  input wire [7:0] pull_mask, // pins whose pull-up is asked for
  input wire [7:0] data, // output data latch
  input wire [7:0] addr, // address bits from the bus controller
  input wire hw_stby, // hardware standby active
  input wire sw_stby, // software standby active
  input wire hold, // address pins keep level in software standby
  input wire [7:0] cur_out, // present pin level
  input wire [7:0] cur_oe_n, // present enable, low drives
  output reg [7:0] next_out, // next pin level
  output reg [7:0] next_oe_n, // next enable, low drives
  output reg [7:0] next_pu // next pull-up enable
);

  // ==========================================================
  // per pin stage
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_pin
      always @*
      begin
        next_out[i] = addr_mask[i] ? addr[i] : data[i];
        next_oe_n[i] = ~(addr_mask[i] | gpio_mask[i]);
        // open drain: only the low level is driven
        if (od_mask[i] && next_out[i])
        begin
          next_oe_n[i] = 1'b1;
        end
        next_pu[i] = pull_mask[i];
        if (hw_stby)
        begin
          next_out[i] = 1'b0;
          next_oe_n[i] = 1'b1;
          next_pu[i] = 1'b0;
        end
        else if (sw_stby && addr_mask[i])
        begin
          if (hold)
          begin
            next_out[i] = cur_out[i];
            next_oe_n[i] = cur_oe_n[i];
          end
          else
          begin
            next_oe_n[i] = 1'b1;
          end
        end
      end
    end
  endgenerate

endmodule

// ### test/dap_io_port_asserts.sv
/*
  checker of the apb answer and the pin outputs of dap_io_port.
  assumes it is bound to dap_io_port and sees only its ports.
*/
`timescale 1ns/1ps

module dap_io_port_chk
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic [17:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [2:0] mode_pin, // mode
  input wire logic hw_standby_n, // hw standby
  input wire logic sw_standby, // sw standby
  input wire logic [7:0] addr_a, // address a
  input wire logic [7:0] addr_b, // address b
  input wire logic [7:0] pa_out, // a level
  input wire logic [7:0] pa_oe_n, // a enable
  input wire logic [7:0] pa_pullup, // a pull
  input wire logic [7:0] pb_out, // b level
  input wire logic [7:0] pb_oe_n, // b enable
  input wire logic [7:0] pb_pullup // b pull
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire m145 = mode_pin == 3'h1 || mode_pin == 3'h4 || mode_pin == 3'h5;
  wire m45 = mode_pin[2:1] == 2'b10;
  wire run = hw_standby_n && !sw_standby;

  // ==========================================================
  // bus answer
  a_ready_one: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  a_err_align: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
    else $error("no error on unaligned access");
  a_err_zero: assert property (pslverr |-> prdata == 32'h0)
    else $error("read data not zero with error");

  // ==========================================================
  // pins
  a_pa_pull_in: assert property ((pa_pullup & ~pa_oe_n) == 8'h00)
    else $error("port a pull-up on a driven pin");
  a_pb_pull_in: assert property ((pb_pullup & ~pb_oe_n) == 8'h00)
    else $error("port b pull-up on a driven pin");
  a_pb_addr_all: assert property ((m145 && run)[*5] |->
    pb_oe_n == 8'h00 && pb_out == $past(addr_b))
    else $error("port b not driving address");
  a_pb_pull_off: assert property (m145[*5] |-> pb_pullup == 8'h00)
    else $error("port b pull-up on in address mode");
  a_pa_low_addr: assert property ((m45 && run)[*5] |->
    pa_oe_n[4:0] == 5'h00 && pa_pullup[4:0] == 5'h00)
    else $error("port a low pins not address");
  a_pa_addr_out: assert property ((m45 && run)[*5] |->
    pa_out[4:0] == $past(addr_a[4:0]))
    else $error("port a low pins not showing address bits");
  a_hw_release: assert property ((!hw_standby_n)[*4] |->
    (pa_oe_n & pb_oe_n) == 8'hFF && (pa_pullup | pb_pullup) == 8'h00)
    else $error("pins not released in hardware standby");

  cover property (pready && pslverr);
  cover property (m145[*5]);
  cover property (sw_standby && pb_oe_n == 8'h00);
endmodule

bind dap_io_port dap_io_port_chk u_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_pin(mode_pin),
  .hw_standby_n(hw_standby_n), .sw_standby(sw_standby), .addr_a(addr_a), .addr_b(addr_b),
  .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pa_pullup(pa_pullup), .pb_out(pb_out),
  .pb_oe_n(pb_oe_n), .pb_pullup(pb_pullup)
);

// ### test/dap_board_model.sv
/*
  board side of both ports: pin levels and the external address bus.
  assumes the bench sets ext_en, ext_a and ext_b for undriven pins.
*/
`timescale 1ns/1ps

module dap_board_model
(
  input wire logic pclk, // clock
  input wire logic ext_en, // outside driver on
  input wire logic [7:0] ext_a, // outside level a
  input wire logic [7:0] ext_b, // outside level b
  input wire logic [7:0] pa_out, // a level
  input wire logic [7:0] pa_oe_n, // a enable
  input wire logic [7:0] pa_pullup, // a pull
  input wire logic [7:0] pb_out, // b level
  input wire logic [7:0] pb_oe_n, // b enable
  input wire logic [7:0] pb_pullup, // b pull
  output logic [7:0] pa_in, // a pins
  output logic [7:0] pb_in, // b pins
  output logic [7:0] addr_a, // address a
  output logic [7:0] addr_b // address b
);
  logic [7:0] last_a = 8'h00;
  logic [7:0] last_b = 8'h00;
  logic [7:0] step = 8'h00;

  // floating pins without pull-up toggle so no stale level reads back
  function automatic logic [7:0] pin(input logic [7:0] o, n, u, e, l, input logic x);
    pin = (~n & o) | (n & (x ? e : (u | ~l)));
  endfunction

  assign pa_in = pin(pa_out, pa_oe_n, pa_pullup, ext_a, last_a, ext_en);
  assign pb_in = pin(pb_out, pb_oe_n, pb_pullup, ext_b, last_b, ext_en);
  // odd steps give a new address value every cycle
  assign addr_a = step * 8'h35;
  assign addr_b = step * 8'h6B;

  always @(posedge pclk)
  begin
    last_a <= pa_in;
    last_b <= pb_in;
    step <= step + 8'h01;
  end
endmodule

// ### test/test_dap_io_port.sv
/*
  self-checking bench of dap_io_port over apb with a board model.
  assumes the register map header and one pclk domain.
*/
`timescale 1ns/1ps
`include "dap_regs.vh"

module test_dap_io_port;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic hw_standby_n, manual_reset_n, sw_standby, ext_en;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [2:0] mode_pin;
  logic [7:0] addr_a, addr_b, pa_in, pa_out, pa_oe_n, pa_pullup, ext_a, ext_b;
  logic [7:0] pb_in, pb_out, pb_oe_n, pb_pullup, r_dir, r_dat, r_pul, r_ext, snap;
  logic [9:0] notes[$];
  int fails, comparisons, m;

  dap_io_port u_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode_pin(mode_pin), .hw_standby_n(hw_standby_n),
    .manual_reset_n(manual_reset_n), .sw_standby(sw_standby), .addr_a(addr_a),
    .addr_b(addr_b), .pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n),
    .pa_pullup(pa_pullup), .pb_in(pb_in), .pb_out(pb_out), .pb_oe_n(pb_oe_n),
    .pb_pullup(pb_pullup)
  );
  dap_board_model u_board
  (
    .pclk(pclk), .ext_en(ext_en), .ext_a(ext_a), .ext_b(ext_b), .pa_out(pa_out),
    .pa_oe_n(pa_oe_n), .pa_pullup(pa_pullup), .pb_out(pb_out), .pb_oe_n(pb_oe_n),
    .pb_pullup(pb_pullup), .pa_in(pa_in), .pb_in(pb_in), .addr_a(addr_a), .addr_b(addr_b)
  );

  // ==========================================================
  // compare and report
  task automatic bad(input string s);
    fails++;
    $display("mismatch at %0t: %s", $time, s);
  endtask
  task automatic cmp_pin(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp)
      bad($sformatf("pin %h expected %h", got, exp));
  endtask
  task automatic cmp_bus(input logic [9:0] n);
    comparisons++;
    if (pslverr !== n[8] || (n[9] && prdata !== {24'h0, n[7:0]}))
      bad($sformatf("bus %h err %b expected %h", prdata, pslverr, n));
  endtask
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================
  // apb master; a note is {check data, error, data}
  task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] d,
                      input logic [9:0] n, input logic [1:0] lo);
    int k;
    k = 0;
    notes.push_back(n);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, lo};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      bad("no ready");
      stop_test;
    end
    else
    begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    xfer(1'b1, i, d, 10'h000, 2'b00);
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] e);
    xfer(1'b0, i, 8'h00, {2'b10, e}, 2'b00);
  endtask

  // answers are taken at the edge that completes the access
  always @(posedge pclk)
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
    begin
      if (notes.size() == 0)
        bad("answer without request");
      else
        cmp_bus(notes.pop_front());
    end

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ==========================================================
  // scenarios
  initial
  begin
    {presetn, psel, penable, pwrite, sw_standby} = 5'b0;
    {hw_standby_n, manual_reset_n, ext_en} = 3'b111;
    paddr = 18'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    mode_pin = 3'h7;
    ext_a = 8'hA5;
    void'($urandom(32'hce28));
    r_dir = 8'($urandom);
    r_dat = 8'($urandom);
    r_pul = 8'($urandom);
    r_ext = 8'($urandom);
    ext_b = r_ext;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(`DAP_IDX_PB_DIR, `DAP_UNDEF_READ);
    rd(`DAP_IDX_PB_DATA, 8'h00);
    rd(`DAP_IDX_PB_PULL, 8'h00);
    rd(`DAP_IDX_PA_ODS, 8'h00);
    wr(`DAP_IDX_PB_DIR, r_dir);
    wr(`DAP_IDX_PB_DATA, r_dat);
    wr(`DAP_IDX_PB_PULL, r_pul);
    wr(`DAP_IDX_PB_PIN, ~r_dat);
    rd(`DAP_IDX_PB_DIR, `DAP_UNDEF_READ);
    rd(`DAP_IDX_PB_PIN, r_dir & r_dat | ~r_dir & r_ext);
    cmp_pin(pb_out & r_dir, r_dat & r_dir);
    wr(`DAP_IDX_PA_DIR, 8'h33);
    wr(`DAP_IDX_PA_DATA, 8'h0F);
    wr(`DAP_IDX_PA_ODS, 8'h0F);
    wr(`DAP_IDX_PA_PULL, 8'hFF);
    rd(`DAP_IDX_PA_PIN, 8'h87);
    for (m = 1; m < 8; m++)
    begin
      mode_pin <= 3'(m);
      repeat (6) @(posedge pclk);
      cmp_pin(pa_oe_n, m inside {4, 5} ? 8'hC0 : m == 6 ? 8'hCC : 8'hCF);
      cmp_pin(pa_pullup, m inside {4, 5} ? 8'hC0 : 8'hCC);
      cmp_pin(pb_oe_n, m inside {1, 4, 5} ? 8'h00 : ~r_dir);
      cmp_pin(pb_pullup, m inside {1, 4, 5} ? 8'h00 : r_pul & ~r_dir);
      if (!(m inside {4, 5, 6}))
        cmp_pin(pa_out, 8'h0F);
    end
    mode_pin <= 3'h1;
    wr(`DAP_IDX_STBY, 8'h00);
    repeat (5) @(posedge pclk);
    sw_standby <= 1'b1;
    repeat (3) @(posedge pclk);
    cmp_pin(pb_oe_n, 8'hFF);
    sw_standby <= 1'b0;
    wr(`DAP_IDX_STBY, 8'h08);
    sw_standby <= 1'b1;
    repeat (3) @(posedge pclk);
    snap = pb_out;
    repeat (3) @(posedge pclk);
    cmp_pin(pb_oe_n, 8'h00);
    cmp_pin(pb_out, snap);
    rd(`DAP_IDX_STBY, 8'h09);
    sw_standby <= 1'b0;
    mode_pin <= 3'h7;
    repeat (6) @(posedge pclk);
    manual_reset_n <= 1'b0;
    repeat (3) @(posedge pclk);
    ext_b <= ~r_ext;
    wr(`DAP_IDX_PB_DATA, ~r_dat);
    rd(`DAP_IDX_PB_DATA, r_dat);
    rd(`DAP_IDX_PB_PIN, r_dir & r_dat | ~r_dir & r_ext);
    rd(`DAP_IDX_PA_ODS, 8'h0F);
    cmp_pin(pb_pullup, r_pul & ~r_dir);
    cmp_pin(pa_pullup, 8'hCC);
    manual_reset_n <= 1'b1;
    hw_standby_n <= 1'b0;
    repeat (5) @(posedge pclk);
    hw_standby_n <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`DAP_IDX_PB_DATA, 8'h00);
    rd(`DAP_IDX_PB_PULL, 8'h00);
    rd(`DAP_IDX_PA_ODS, 8'h00);
    rd(`DAP_IDX_PB_PIN, ~r_ext);
    cmp_pin(pb_oe_n, 8'hFF);
    cmp_pin(pa_pullup, 8'h00);
    xfer(1'b0, 16'h0001, 8'h00, 10'h300, 2'b00);
    xfer(1'b1, `DAP_IDX_PB_DATA, 8'h5A, 10'h100, 2'b10);
    rd(`DAP_IDX_PB_DATA, 8'h00);
    repeat (3) @(posedge pclk);
    if (notes.size() != 0)
      bad("answers missing");
    stop_test;
  end
endmodule
